// File: rtl/bst_defs.vh
// constants for the bisync synchronous transmitter
`ifndef BST_DEFS_VH
`define BST_DEFS_VH

// register byte offsets on the apb bus
`define BST_OFF_CMD       8'h00
`define BST_OFF_ICR       8'h04
`define BST_OFF_RCR       8'h08
`define BST_OFF_MODE      8'h0C
`define BST_OFF_TCR       8'h10
`define BST_OFF_SYNC1     8'h14
`define BST_OFF_SYNC2     8'h18
`define BST_OFF_DATA      8'h1C
`define BST_OFF_STAT      8'h20

// command register bits (write one to act)
`define BST_CMD_RST_CRC   0
`define BST_CMD_RST_TXIP  1
`define BST_CMD_RST_EOM   2
`define BST_CMD_CHAN_RST  3
`define BST_CMD_RST_EXT   4

// interrupt control bits
`define BST_ICR_EXT_IE    0
`define BST_ICR_TX_IE     1
`define BST_ICR_WR_EN     2
`define BST_ICR_RDY_MODE  3

// receiver control: auto enables
`define BST_RCR_AUTO      5

// channel mode sync field
`define BST_MODE_SYNC_HI  5
`define BST_MODE_SYNC_LO  4
`define BST_SYNC_8        2'b00
`define BST_SYNC_16       2'b01
`define BST_SYNC_SDLC     2'b10
`define BST_SYNC_EXT      2'b11

// transmitter control bits
`define BST_TCR_CRC_EN    0
`define BST_TCR_RTS       1
`define BST_TCR_CRC16     2
`define BST_TCR_TX_EN     3
`define BST_TCR_BREAK     4
`define BST_TCR_LEN_HI    6
`define BST_TCR_LEN_LO    5
`define BST_TCR_DTR       7

// status bits
`define BST_ST_TXIP       0
`define BST_ST_EXTIP      1
`define BST_ST_TBE        2
`define BST_ST_CTS        5
`define BST_ST_EOM        6

// reset values
`define BST_RST_REG8      8'h00
`define BST_RST_EOM       1'b1

// crc polynomials without the x16 term
`define BST_POLY_CRC16    16'h8005
`define BST_POLY_SDLC     16'h1021
`define BST_CRC_INIT      16'h0000

`endif

// File: rtl/bst_crc.v
// serial crc generator with selectable polynomial
`timescale 1ns/1ps
`include "bst_defs.vh"

module bst_crc (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clr,
	input  wire        step,
	input  wire        din,
	input  wire        sel16,
	output reg  [15:0] crc_reg
);

	reg  [15:0] crc_next;
	wire        fb;
	wire [15:0] poly;

	assign fb   = din ^ crc_reg[15];
	// R1: polynomial select
	assign poly = sel16 ? `BST_POLY_CRC16 : `BST_POLY_SDLC;

	always @* begin
		crc_next = crc_reg;
		// R2: clear to zeros
		if (clr) begin
			crc_next = `BST_CRC_INIT;
		end else if (step) begin
			crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_reg <= `BST_CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

endmodule

// File: rtl/bst_transmitter.v
// bisync transmit channel with apb register access
`timescale 1ns/1ps
`include "bst_defs.vh"

// Summary of operation
// R1: crc uses crc-16 or sdlc polynomial, picked by transmitter control bit
// R2: reset-crc command clears the generator to all zeros
// R3: with auto enables set, transmitter runs only while cts is active
// R4: line marks after reset or while transmitter is not enabled
// R5: send-break forces spacing at once
// R6: idle enabled transmitter sends the 8 or 16 bit sync pattern
// R7: with tx interrupt enabled, buffer full-to-empty raises tx interrupt
// R8: tx interrupt clears on data write or reset-pending command
// R9: wait stalls cpu writes to a full buffer; ready flags empty buffer
// R10: empty shifter with no data enters underrun and sends filler
// R11: latch set after reset; inserted syncs are kept out of crc
// R12: cleared latch makes next underrun send crc, then sync, set latch
// R13: latch going clear to set raises external/status interrupt
// R14: sync underrun interrupt comes after first inserted sync loads
// R15: buffer-empty reads clear during crc, then sets with tx interrupt
// R16: data written during crc follows it instead of sync
// R17: crc enable starts accumulation with the next data character
// R18: crc inclusion taken from enable bit at shifter load time
// R19: underrun sends first then second sync register for dle-syn pairs
// R20: disabling lets the current character finish, then line marks
// R21: mode bits 5:4 pick 8-bit, 16-bit, sdlc or external sync; code acts only on 16-bit, sdlc and external send one sync as 8-bit
// R22: length bits 6:5: 00 five, 10 six, 01 seven, 11 eight bits
// R23: bits change on falling edge of the x1 transmit clock
// R24: least significant bit first, short characters right-justified
// R25: sync mode decides whether one or two sync registers go out
module bst_transmitter (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        txc,
	input  wire        cts_n,
	output reg         txd,
	output reg         rts_n,
	output reg         dtr_n,
	output reg         wait_rdy_n,
	output reg         tx_irq,
	output reg         ext_irq
);

	localparam K_DATA  = 2'd0;
	localparam K_SYNC1 = 2'd1;
	localparam K_SYNC2 = 2'd2;
	localparam K_CRC   = 2'd3;

	reg  [7:0]  icr_reg;
	reg  [7:0]  rcr_reg;
	reg  [7:0]  mode_reg;
	reg  [7:0]  tcr_reg;
	reg  [7:0]  sync1_reg;
	reg  [7:0]  sync2_reg;
	reg  [7:0]  buf_reg;
	reg         buf_full_reg;
	reg         eom_reg;
	reg         txip_reg;
	reg         extip_reg;
	reg         prev_data_reg;
	reg  [15:0] sh_reg;
	reg  [4:0]  cnt_reg;
	reg  [1:0]  kind_reg;
	reg         busy_reg;
	reg         incl_reg;
	reg         txc_s1_reg;
	reg         txc_s2_reg;
	reg         txc_d_reg;
	reg         cts_s1_reg;
	reg         cts_s2_reg;

	wire [15:0] crc_val;
	wire [15:0] crc_poly;
	wire [15:0] crc_adv;
	wire        acc;
	wire        stall;
	wire        go;
	wire        wr;
	wire        cmd_wr;
	wire        data_wr;
	wire        tick;
	wire        cts_on;
	wire        tx_on;
	wire        brk;
	wire        wait_mode;
	wire        sync16;
	wire        last_bit;
	wire        crc_clr;
	wire        crc_step;
	wire        chan_rst;
	wire        tbe;

	reg  [1:0]  ld_kind;
	reg  [15:0] ld_val;
	reg  [4:0]  ld_len;
	reg         ld_incl;
	reg  [4:0]  data_len;
	reg         load;
	reg         unmapped;
	reg  [7:0]  rd_val;

	// apb access: one wait state, data write stalled while buffer full in wait mode
	assign acc       = psel & penable & ~pready;
	assign wait_mode = icr_reg[`BST_ICR_WR_EN] & ~icr_reg[`BST_ICR_RDY_MODE];
	// R9: wait mode extends the cpu write cycle
	assign stall     = pwrite & (paddr == `BST_OFF_DATA) & wait_mode &
	                   buf_full_reg;
	assign go        = acc & ~stall;
	assign wr        = go & pwrite & ~unmapped;
	assign cmd_wr    = wr & (paddr == `BST_OFF_CMD);
	assign data_wr   = wr & (paddr == `BST_OFF_DATA);
	assign chan_rst  = cmd_wr & pwdata[`BST_CMD_CHAN_RST];

	// R23: falling edge of the synchronised transmit clock
	assign tick   = txc_d_reg & ~txc_s2_reg;
	assign cts_on = ~cts_s2_reg;
	// R3: auto enables gate on cts
	assign tx_on  = tcr_reg[`BST_TCR_TX_EN] &
	                (~rcr_reg[`BST_RCR_AUTO] | cts_on);
	assign brk    = tcr_reg[`BST_TCR_BREAK];
	// R21: sync mode field decode
	// R25: two sync registers only in 16-bit sync
	assign sync16 = ({mode_reg[`BST_MODE_SYNC_HI],
	                  mode_reg[`BST_MODE_SYNC_LO]} == `BST_SYNC_16);
	assign last_bit = busy_reg & (cnt_reg == 5'd1);
	// R2: reset-crc command
	assign crc_clr  = (cmd_wr & pwdata[`BST_CMD_RST_CRC]) | chan_rst;
	// R11: only characters marked for inclusion feed the crc
	assign crc_step = tick & busy_reg & incl_reg & ~brk;
	// R15: buffer-empty reads clear while crc goes out
	assign tbe = ~buf_full_reg & ~(busy_reg & (kind_reg == K_CRC));
	// R12: crc as it stands after the bit shifted on the load tick
	assign crc_poly = tcr_reg[`BST_TCR_CRC16] ? `BST_POLY_CRC16 :
	                  `BST_POLY_SDLC;
	assign crc_adv  = crc_step ?
	                  ({crc_val[14:0], 1'b0} ^
	                   ((sh_reg[0] ^ crc_val[15]) ? crc_poly : 16'h0000)) :
	                  crc_val;

	bst_crc u_crc (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (crc_clr),
		.step    (crc_step),
		.din     (sh_reg[0]),
		.sel16   (tcr_reg[`BST_TCR_CRC16]),
		.crc_reg (crc_val)
	);

	// R22: character length decode
	always @* begin
		case ({tcr_reg[`BST_TCR_LEN_HI], tcr_reg[`BST_TCR_LEN_LO]})
		2'b00: data_len = 5'd5;
		2'b10: data_len = 5'd6;
		2'b01: data_len = 5'd7;
		default: data_len = 5'd8;
		endcase
	end

	// next character into the shifter
	always @* begin
		ld_kind = K_SYNC1;
		ld_val  = {8'h00, sync1_reg};
		ld_len  = 5'd8;
		ld_incl = 1'b0;
		if (busy_reg & (kind_reg == K_SYNC1) & sync16) begin
			// R19: second sync register follows the first
			// keeps dle-syn pairs whole; data waits one character
			ld_kind = K_SYNC2;
			ld_val  = {8'h00, sync2_reg};
		end else if (buf_full_reg) begin
			// R16: written data displaces sync after crc
			// R18: crc inclusion sampled at load
			// R24: right-justified, lsb out first
			ld_kind = K_DATA;
			ld_val  = {8'h00, buf_reg};
			ld_len  = data_len;
			// R17: accumulation starts with next data
			ld_incl = tcr_reg[`BST_TCR_CRC_EN];
		end else if (~eom_reg & prev_data_reg) begin
			// R12: end of message sends crc
			ld_kind = K_CRC;
			ld_val  = crc_adv;
			ld_len  = 5'd16;
		end
	end

	always @* begin
		// R10: shifter empty, filler chosen above
		// R20: disabled transmitter loads nothing more
		load = tick & tx_on & ~brk & (~busy_reg | last_bit);
	end

	// register map decode
	always @* begin
		unmapped = 1'b0;
		rd_val   = 8'h00;
		case (paddr)
		`BST_OFF_CMD:   rd_val = 8'h00;
		`BST_OFF_ICR:   rd_val = icr_reg;
		`BST_OFF_RCR:   rd_val = rcr_reg;
		`BST_OFF_MODE:  rd_val = mode_reg;
		`BST_OFF_TCR:   rd_val = tcr_reg;
		`BST_OFF_SYNC1: rd_val = sync1_reg;
		`BST_OFF_SYNC2: rd_val = sync2_reg;
		`BST_OFF_DATA:  rd_val = 8'h00;
		`BST_OFF_STAT: begin
			rd_val[`BST_ST_TXIP]  = txip_reg;
			rd_val[`BST_ST_EXTIP] = extip_reg;
			rd_val[`BST_ST_TBE]   = tbe;
			rd_val[`BST_ST_CTS]   = cts_on;
			rd_val[`BST_ST_EOM]   = eom_reg;
		end
		default: unmapped = 1'b1;
		endcase
	end

	// pin synchronisers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txc_s1_reg <= 1'b1;
			txc_s2_reg <= 1'b1;
			txc_d_reg  <= 1'b1;
			cts_s1_reg <= 1'b1;
			cts_s2_reg <= 1'b1;
		end else begin
			txc_s1_reg <= txc;
			txc_s2_reg <= txc_s1_reg;
			txc_d_reg  <= txc_s2_reg;
			cts_s1_reg <= cts_n;
			cts_s2_reg <= cts_s1_reg;
		end
	end

	// apb answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= go;
			pslverr <= go & unmapped;
			if (go & ~pwrite) begin
				prdata <= {24'h00_0000, rd_val};
			end
		end
	end

	// control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			icr_reg   <= `BST_RST_REG8;
			rcr_reg   <= `BST_RST_REG8;
			mode_reg  <= `BST_RST_REG8;
			tcr_reg   <= `BST_RST_REG8;
			sync1_reg <= `BST_RST_REG8;
			sync2_reg <= `BST_RST_REG8;
		end else if (chan_rst) begin
			icr_reg <= `BST_RST_REG8;
			tcr_reg <= `BST_RST_REG8;
		end else if (wr) begin
			case (paddr)
			`BST_OFF_ICR:   icr_reg   <= pwdata[7:0];
			`BST_OFF_RCR:   rcr_reg   <= pwdata[7:0];
			`BST_OFF_MODE:  mode_reg  <= pwdata[7:0];
			`BST_OFF_TCR:   tcr_reg   <= pwdata[7:0];
			`BST_OFF_SYNC1: sync1_reg <= pwdata[7:0];
			`BST_OFF_SYNC2: sync2_reg <= pwdata[7:0];
			default: ;
			endcase
		end
	end

	// buffer, latch and pending flags; sets are applied after clears, but break empties the buffer last
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_reg       <= `BST_RST_REG8;
			buf_full_reg  <= 1'b0;
			eom_reg       <= `BST_RST_EOM;
			txip_reg      <= 1'b0;
			extip_reg     <= 1'b0;
			prev_data_reg <= 1'b0;
		end else if (chan_rst) begin
			// R11: channel reset sets the latch
			buf_full_reg  <= 1'b0;
			eom_reg       <= `BST_RST_EOM;
			txip_reg      <= 1'b0;
			extip_reg     <= 1'b0;
			prev_data_reg <= 1'b0;
		end else begin
			// R8: clears by write or command
			if (data_wr | (cmd_wr & pwdata[`BST_CMD_RST_TXIP])) begin
				txip_reg <= 1'b0;
			end
			if (cmd_wr & pwdata[`BST_CMD_RST_EXT]) begin
				extip_reg <= 1'b0;
			end
			if (cmd_wr & pwdata[`BST_CMD_RST_EOM]) begin
				eom_reg <= 1'b0;
			end
			if (data_wr) begin
				buf_reg      <= pwdata[7:0];
				buf_full_reg <= 1'b1;
			end
			// R5: break discards buffered data
			if (brk) begin
				buf_full_reg <= 1'b0;
			end
			if (load) begin
				case (ld_kind)
				K_DATA: begin
					buf_full_reg  <= data_wr;
					prev_data_reg <= 1'b1;
					// R7: full-to-empty transition
					if (icr_reg[`BST_ICR_TX_IE]) begin
						txip_reg <= 1'b1;
					end
				end
				K_CRC: begin
					prev_data_reg <= 1'b0;
					// R12: latch sets as crc starts
					eom_reg <= 1'b1;
					// R13: clear-to-set of the latch
					if (~eom_reg) begin
						extip_reg <= 1'b1;
					end
				end
				K_SYNC1: begin
					prev_data_reg <= 1'b0;
					// R14: first inserted sync after data
					if (prev_data_reg) begin
						extip_reg <= 1'b1;
					end
					// R15: crc finished, new message may start
					if (busy_reg & (kind_reg == K_CRC) &
					    icr_reg[`BST_ICR_TX_IE]) begin
						txip_reg <= 1'b1;
					end
				end
				default: ;
				endcase
			end
		end
	end

	// serial shifter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_reg   <= 16'h0000;
			cnt_reg  <= 5'd0;
			kind_reg <= K_SYNC1;
			busy_reg <= 1'b0;
			incl_reg <= 1'b0;
		end else if (brk | chan_rst) begin
			// R5: shifter contents are lost on break
			busy_reg <= 1'b0;
			cnt_reg  <= 5'd0;
			incl_reg <= 1'b0;
		end else if (load) begin
			// R6: idle enabled line keeps loading sync
			sh_reg   <= ld_val;
			cnt_reg  <= ld_len;
			kind_reg <= ld_kind;
			incl_reg <= ld_incl;
			busy_reg <= 1'b1;
		end else if (tick & busy_reg) begin
			// R20: current character completes unless break or channel reset
			sh_reg  <= {1'b0, sh_reg[15:1]};
			cnt_reg <= cnt_reg - 5'd1;
			if (last_bit) begin
				busy_reg <= 1'b0;
				incl_reg <= 1'b0;
			end
		end
	end

	// line and modem outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// R4: marking after reset
			txd        <= 1'b1;
			rts_n      <= 1'b1;
			dtr_n      <= 1'b1;
			wait_rdy_n <= 1'b1;
			tx_irq     <= 1'b0;
			ext_irq    <= 1'b0;
		end else begin
			if (brk) begin
				// R5: spacing at once
				txd <= 1'b0;
			end else if (tick) begin
				// R24: lsb of the shifter goes out
				// R4: idle ticks mark; the last bit keeps its full cell
				txd <= busy_reg ? sh_reg[0] : 1'b1;
			end
			rts_n   <= ~tcr_reg[`BST_TCR_RTS];
			dtr_n   <= ~tcr_reg[`BST_TCR_DTR];
			tx_irq  <= txip_reg;
			ext_irq <= extip_reg & icr_reg[`BST_ICR_EXT_IE];
			// R9: wait low on full buffer, ready low on empty
			if (icr_reg[`BST_ICR_WR_EN]) begin
				wait_rdy_n <= icr_reg[`BST_ICR_RDY_MODE] ?
				              buf_full_reg : ~buf_full_reg;
			end else begin
				wait_rdy_n <= 1'b1;
			end
		end
	end

endmodule

// File: tb/bst_tx_props.sv
// port-level checks for the bisync transmitter
`timescale 1ns/1ps
`include "bst_defs.vh"

module bst_tx_props (
	input wire        pclk,
	input wire        presetn,
	input wire [7:0]  paddr,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        txc,
	input wire        cts_n,
	input wire        txd,
	input wire        rts_n,
	input wire        dtr_n,
	input wire        wait_rdy_n,
	input wire        tx_irq,
	input wire        ext_irq
);
	wire       take;
	reg  [7:0] icr_reg;
	reg  [7:0] tcr_reg;
	reg  [7:0] idle_reg;

	// a stalled data write repeats take, harmless for these shadows
	assign take = psel & penable & pwrite & ~pready;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			icr_reg <= 8'h00;
			tcr_reg <= 8'h00;
		end else if (take && paddr == `BST_OFF_CMD && pwdata[3]) begin
			icr_reg <= 8'h00;
			tcr_reg <= 8'h00;
		end else if (take && paddr == `BST_OFF_ICR) begin
			icr_reg <= pwdata[7:0];
		end else if (take && paddr == `BST_OFF_TCR) begin
			tcr_reg <= pwdata[7:0];
		end
	end
	// longest unit is 16 crc bits at 8 pclk each, plus slack
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_reg <= 8'h00;
		else if (tcr_reg[3] | tcr_reg[4])
			idle_reg <= 8'h00;
		else if (idle_reg != 8'hA0)
			idle_reg <= idle_reg + 8'h01;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence brk_wr_s;
		take && paddr == `BST_OFF_TCR && pwdata[`BST_TCR_BREAK];
	endsequence
	sequence txp_rst_s;
		take && paddr == `BST_OFF_CMD && pwdata[`BST_CMD_RST_TXIP];
	endsequence

	reset_mark_a: assert property ($rose(presetn) |-> txd [*8])
		else $error("line not marking after reset");
	break_space_a: assert property (brk_wr_s |-> ##[0:2] !txd)
		else $error("break did not space the line");
	tx_irq_gate_a: assert property ($rose(tx_irq) |-> icr_reg[1])
		else $error("tx interrupt while disabled");
	ext_irq_gate_a: assert property ($rose(ext_irq) |-> icr_reg[0])
		else $error("status interrupt while disabled");
	txp_clear_a: assert property (txp_rst_s |-> ##[1:2] !tx_irq)
		else $error("tx interrupt not cleared by command");
	wait_off_a: assert property (!icr_reg[2] |=> wait_rdy_n)
		else $error("wait/ready active while disabled");
	idle_mark_a: assert property (idle_reg == 8'hA0 |-> txd)
		else $error("line not marking when disabled");
	txd_edge_a: assert property ($changed(txd) |-> tcr_reg[4] ||
		$past(tcr_reg[4], 3) || !$past(txc, 2) || !$past(txc, 3)
		|| !$past(txc, 4)) else $error("txd moved off a clock fall");
endmodule

bind bst_transmitter bst_tx_props props_u (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.txc(txc), .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
	.wait_rdy_n(wait_rdy_n), .tx_irq(tx_irq), .ext_irq(ext_irq));

// File: tb/bst_modem.sv
// far station: makes the x1 clock, hunts sync, collects bytes
`timescale 1ns/1ps

module bst_modem (
	output logic      txc,
	output logic      cts_n,
	input  wire logic txd,
	input  wire logic cts_on,
	input  wire logic hunt
);
	localparam logic [7:0] SYNC = 8'h16;
	logic [7:0] sh_reg;
	logic       lock_reg = 1'h0;
	int         cnt = 0;
	logic [7:0] rxq[$];

	// runs free: idle sync fill needs a live clock
	initial begin
		txc = 1'h1;
		#137;
		forever #400 txc = ~txc;
	end
	assign cts_n = ~cts_on;
	// lsb first assembly; mid-bit sample, device moves txd late
	always @(negedge txc) begin
		sh_reg = {txd, sh_reg[7:1]};
		cnt = cnt + 1;
		if (hunt)
			lock_reg = 1'h0;
		else if (!lock_reg && sh_reg == SYNC) begin
			lock_reg = 1'h1;
			cnt = 0;
		end else if (lock_reg && cnt == 8) begin
			cnt = 0;
			if (sh_reg != SYNC)
				rxq.push_back(sh_reg);
		end
	end
endmodule

// File: tb/bst_transmitter_tb.sv
// self-checking bench for the bisync transmitter
`timescale 1ns/1ps
`include "bst_defs.vh"

module bst_transmitter_tb;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;
		logic e;} bst_row_t;
	logic        pclk, presetn, psel, penable, pwrite, err, cts_on, hunt;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, txc, cts_n, txd, rts_n, dtr_n;
	logic        wait_rdy_n, tx_irq, ext_irq;
	logic [15:0] crc;
	logic [7:0]  exp_q[$];
	int          n_fail, compares, n;
	bst_row_t    rows[7] = '{'{8'h04, 8'h0E, 8'h0E, 1'h0},
		'{8'h08, 8'h5A, 8'h5A, 1'h0}, '{8'h0C, 8'hA5, 8'hA5, 1'h0},
		'{8'h10, 8'h86, 8'h86, 1'h0}, '{8'h14, 8'h3C, 8'h3C, 1'h0},
		'{8'h18, 8'hC3, 8'hC3, 1'h0}, '{8'h24, 8'h77, 8'h00, 1'h1}};

	bst_transmitter dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .txc(txc),
		.cts_n(cts_n), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
		.wait_rdy_n(wait_rdy_n), .tx_irq(tx_irq), .ext_irq(ext_irq));
	bst_modem modem_u (.txc(txc), .cts_n(cts_n), .txd(txd),
		.cts_on(cts_on), .hunt(hunt));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task end_sim();
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 3000);
		if (pready !== 1'h1)
			n_fail++;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task ticks(input int k);
		repeat (k) @(posedge txc);
		@(posedge pclk);
	endtask
	task wait_ext();
		n = 0;
		while (ext_irq !== 1'h1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	function automatic logic [15:0] crc8(input logic [15:0] c,
		input logic [7:0] d, input logic [15:0] p);
		for (int i = 0; i < 8; i++)
			c = {c[14:0], 1'h0} ^ ((d[i] ^ c[15]) ? p : 16'h0000);
		return c;
	endfunction

	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		end_sim();
	end
	initial begin
		{presetn, psel, penable, pwrite, cts_on, hunt} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		n_fail = 0;
		compares = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(`BST_OFF_STAT, 1'h0, 8'h00);
		chk(rd, 32'h0000_0044);
		foreach (rows[i]) begin
			apb(rows[i].a, 1'h1, rows[i].d);
			chk(err, rows[i].e);
			apb(rows[i].a, 1'h0, 8'h00);
			chk({err, rd[7:0]}, {rows[i].e, rows[i].r});
		end
		chk({wait_rdy_n, rts_n, dtr_n}, 3'h0);
		apb(`BST_OFF_CMD, 1'h1, 8'h08);
		apb(`BST_OFF_STAT, 1'h0, 8'h00);
		chk(rd, 32'h0000_0044);
		chk({wait_rdy_n, rts_n, dtr_n}, 3'h7);
		apb(`BST_OFF_RCR, 1'h1, 8'h20);
		apb(`BST_OFF_MODE, 1'h1, 8'h00);
		apb(`BST_OFF_SYNC1, 1'h1, 8'h16);
		apb(`BST_OFF_TCR, 1'h1, 8'h68);
		ticks(20);
		chk({txd, modem_u.lock_reg}, 2'h2);
		cts_on <= 1'h1;
		ticks(30);
		chk({modem_u.lock_reg, modem_u.rxq.size() == 0}, 2'h3);
		apb(`BST_OFF_ICR, 1'h1, 8'h07);
		apb(`BST_OFF_CMD, 1'h1, 8'h05);
		apb(`BST_OFF_TCR, 1'h1, 8'h6D);
		modem_u.rxq.delete();
		exp_q = '{8'h41, 8'hC2, 8'h03};
		crc = 16'h0000;
		foreach (exp_q[i]) begin
			apb(`BST_OFF_DATA, 1'h1, exp_q[i]);
			crc = crc8(crc, exp_q[i], 16'h8005);
		end
		exp_q.push_back(crc[7:0]);
		exp_q.push_back(crc[15:8]);
		wait_ext();
		chk(ext_irq, 1'h1);
		apb(`BST_OFF_CMD, 1'h1, 8'h02);
		apb(`BST_OFF_STAT, 1'h0, 8'h00);
		chk(rd, 32'h0000_0062);
		ticks(40);
		foreach (exp_q[i])
			chk(modem_u.rxq[i], exp_q[i]);
		chk(tx_irq, 1'h1);
		apb(`BST_OFF_STAT, 1'h0, 8'h00);
		chk(rd & 32'h0000_0044, 32'h0000_0044);
		apb(`BST_OFF_CMD, 1'h1, 8'h12);
		ticks(12);
		chk(tx_irq, 1'h0);
		apb(`BST_OFF_DATA, 1'h1, 8'h55);
		chk(ext_irq, 1'h0);
		wait_ext();
		chk(ext_irq, 1'h1);
		apb(`BST_OFF_STAT, 1'h0, 8'h00);
		chk(rd & 32'h0000_0044, 32'h0000_0044);
		// second message on the sdlc polynomial, pad written during crc
		apb(`BST_OFF_CMD, 1'h1, 8'h15);
		apb(`BST_OFF_TCR, 1'h1, 8'h69);
		modem_u.rxq.delete();
		apb(`BST_OFF_DATA, 1'h1, 8'h5A);
		crc = crc8(16'h0000, 8'h5A, 16'h1021);
		wait_ext();
		apb(`BST_OFF_DATA, 1'h1, 8'hFF);
		ticks(40);
		exp_q = '{8'h5A, crc[7:0], crc[15:8], 8'hFF};
		foreach (exp_q[i])
			chk(modem_u.rxq[i], exp_q[i]);
		apb(`BST_OFF_TCR, 1'h1, 8'h78);
		repeat (2) @(posedge pclk);
		chk(txd, 1'h0);
		apb(`BST_OFF_TCR, 1'h1, 8'h00);
		ticks(24);
		chk(txd, 1'h1);
		apb(`BST_OFF_MODE, 1'h1, 8'h10);
		apb(`BST_OFF_SYNC1, 1'h1, 8'h10);
		apb(`BST_OFF_SYNC2, 1'h1, 8'h16);
		apb(`BST_OFF_TCR, 1'h1, 8'h68);
		hunt <= 1'h1;
		ticks(2);
		hunt <= 1'h0;
		modem_u.rxq.delete();
		ticks(48);
		chk({modem_u.rxq[0], modem_u.rxq[1]}, 16'h1010);
		end_sim();
	end
endmodule
